// ### include/lite_timer_defs.svh
// Register indices, field positions and counts of the lite timebase/watchdog/capture block
`ifndef LITE_TIMER_DEFS_SVH
`define LITE_TIMER_DEFS_SVH

// Register indices; byte address is four times the index
`define LT_CSR_INDEX 6'h0b
`define LT_CAP_INDEX 6'h0c

// Control/status field positions
`define LT_CSR_CAP_IE 7
`define LT_CSR_CAP_F 6
`define LT_CSR_DOUBLE 5
`define LT_CSR_TB_IE 4
`define LT_CSR_TB_F 3
`define LT_CSR_WDG_RF 2
`define LT_CSR_WDG_EN 1
`define LT_CSR_WDG_DLY 0

// Reset values
`define LT_CSR_RESET 8'h00
`define LT_CAP_RESET 8'h00
`define LT_COUNT_RESET 13'h0000

// Counter terminal value before the wrap to zero
`define LT_COUNT_TERMINAL 13'h1f39

// Start-up delay after a wake from halt, in CPU clocks
`define LT_WAKE_SHORT 256
`define LT_WAKE_LONG 512

`endif

// ### include/lite_timer_pkg.sv
// Types shared by the lite timebase/watchdog/capture block
package lite_timer_pkg;

    // Oscillator run state, one-hot
    typedef enum logic [2:0] {
        OSC_RUN = 3'b001,
        OSC_HALTED = 3'b010,
        OSC_WAKING = 3'b100
    } osc_state_t;

endpackage : lite_timer_pkg

// ### rtl/lite_timebase_watchdog_capture.sv
// Lite timer: 13-bit timebase, watchdog and 8-bit input capture behind a Wishbone slave
//
// Summary of operation
// - Counter starts at zero after reset, steps each clock, hidden from software.
// - Overflow event when the count wraps from its terminal value to zero.
// - Double-period select makes a timebase event every second overflow.
// - Timebase event sets the period flag; interrupt requested when enabled.
// - Reading the control/status register clears the period flag.
// - Enabled watchdog resets the device when a period ends without refresh.
// - Delay bit cleared by hardware each period end; only it suppresses reset.
// - Watchdog period runs from reset always; enabling after expiry resets at once.
// - Enable then set the reset flag to force a watchdog reset.
// - Watchdog reset sets the reset flag; reading it clears it.
// - Reset flag left set resets at once when the watchdog is enabled.
// - Hardware watchdog option keeps the watchdog active, enable bit ignored.
// - Option selects whether entering halt gives a watchdog reset.
// - In halt the counter stops and no watchdog reset is made.
// - Wake by interrupt resumes after 256 or 512 clocks; reset disables watchdog.
// - Pin edge latches the counter's upper eight bits and sets the capture flag.
// - Capture interrupt requested when the capture flag and its enable are set.
// - Reading the capture register clears the capture flag.
// - While the capture flag is set further captures are inhibited.
// - Period select: 7994 clock periods when clear, 15988 when set.
// - Only a low-voltage reset clears the watchdog reset flag by hardware.
`timescale 1ns/1ns
`default_nettype none
`include "lite_timer_defs.svh"

module lite_timebase_watchdog_capture
    import lite_timer_pkg::*;
#(
    parameter int WAKE_SHORT = `LT_WAKE_SHORT,
    parameter int WAKE_LONG = `LT_WAKE_LONG
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lvd_reset_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Configuration options
    input wire logic hw_watchdog_option_i,
    input wire logic halt_reset_option_i,
    input wire logic wake_delay_long_i,
    // CPU power state
    input wire logic halt_i,
    // Capture pin
    input wire logic capture_input_pin_i,
    // Interrupt requests and watchdog reset
    output logic period_irq_o,
    output logic capture_irq_o,
    output logic watchdog_reset_o
);

    // ============================================================
    // Wishbone decode
    // ============================================================
    logic take;
    logic csr_hit;
    logic cap_hit;
    logic csr_read;
    logic cap_read;
    logic csr_write;

    // A request is taken once; ack high blocks a second take of the same request
    assign take = cyc_i && stb_i && !ack_o;
    assign csr_hit = (adr_i[7:2] == `LT_CSR_INDEX);
    assign cap_hit = (adr_i[7:2] == `LT_CAP_INDEX);
    assign csr_read = take && !we_i && csr_hit;
    assign cap_read = take && !we_i && cap_hit;
    assign csr_write = take && we_i && csr_hit && sel_i[0];

    // ============================================================
    // Oscillator run state (halt and wake)
    // ============================================================
    osc_state_t osc_state;
    logic [9:0] wake_count;
    logic [9:0] wake_limit;
    logic run;
    logic halt_entry;

    assign run = (osc_state == OSC_RUN);
    assign halt_entry = run && halt_i;
    assign wake_limit = wake_delay_long_i ? 10'(WAKE_LONG - 1) : 10'(WAKE_SHORT - 1);

    // Halt freezes the counter; a wake by interrupt waits out the start-up delay
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_state <= OSC_RUN;
            wake_count <= 10'h000;
        end
        else
        begin
            case (osc_state)
                OSC_RUN:
                begin
                    if (halt_i)
                        osc_state <= OSC_HALTED;
                end
                OSC_HALTED:
                begin
                    wake_count <= 10'h000;
                    if (!halt_i)
                        osc_state <= OSC_WAKING;
                end
                OSC_WAKING:
                begin
                    if (wake_count == wake_limit)
                        osc_state <= OSC_RUN;
                    else
                        wake_count <= wake_count + 10'h001;
                end
                default:
                    osc_state <= OSC_RUN;
            endcase
        end
    end

    // ============================================================
    // Timebase counter
    // ============================================================
    logic [12:0] count;
    logic overflow;
    logic tb_phase;
    logic tb_event;
    logic period_double_select;

    assign overflow = run && (count == `LT_COUNT_TERMINAL);
    assign tb_event = overflow && (!period_double_select || tb_phase);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count <= `LT_COUNT_RESET;
        else if (overflow)
            count <= `LT_COUNT_RESET;
        else if (run)
            count <= count + 13'h0001;
    end

    // Phase of the doubled period; advances on every overflow
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tb_phase <= 1'b0;
        else if (overflow)
            tb_phase <= !tb_phase;
    end

    // ============================================================
    // Control bits written by software
    // ============================================================
    logic period_irq_enable;
    logic capture_irq_enable;
    logic watchdog_enable_bit;

    // Plain read/write bits; a reset leaves the watchdog disabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            capture_irq_enable <= 1'b0;
            period_double_select <= 1'b0;
            period_irq_enable <= 1'b0;
            watchdog_enable_bit <= 1'b0;
        end
        else if (csr_write)
        begin
            capture_irq_enable <= dat_i[`LT_CSR_CAP_IE];
            period_double_select <= dat_i[`LT_CSR_DOUBLE];
            period_irq_enable <= dat_i[`LT_CSR_TB_IE];
            watchdog_enable_bit <= dat_i[`LT_CSR_WDG_EN];
        end
    end

    // ============================================================
    // Timebase flag and interrupt
    // ============================================================
    logic period_event_flag;

    // set on event, cleared by status read; set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            period_event_flag <= 1'b0;
        else if (tb_event)
            period_event_flag <= 1'b1;
        else if (csr_read)
            period_event_flag <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            period_irq_o <= 1'b0;
        else
            period_irq_o <= period_event_flag && period_irq_enable;
    end

    // ============================================================
    // Watchdog
    // ============================================================
    logic wdg_phase;
    logic wdg_end;
    logic watchdog_delay_bit;
    logic wdg_expired;
    logic watchdog_reset_flag;
    logic wdg_active;
    logic delay_write;
    logic wdg_fire;

    // Watchdog period is two counter overflows
    assign wdg_end = overflow && wdg_phase;
    assign delay_write = csr_write && dat_i[`LT_CSR_WDG_DLY];
    // hardware option overrides the enable bit
    assign wdg_active = hw_watchdog_option_i || watchdog_enable_bit;
    assign wdg_fire = wdg_active && ((run && (wdg_expired || watchdog_reset_flag))
                                     || (halt_entry && halt_reset_option_i));

    // period counted from reset whatever the enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wdg_phase <= 1'b0;
        else if (overflow)
            wdg_phase <= !wdg_phase;
    end

    // delay cleared at period end; a write of one in that cycle wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            watchdog_delay_bit <= 1'b0;
        else if (delay_write)
            watchdog_delay_bit <= 1'b1;
        else if (wdg_end)
            watchdog_delay_bit <= 1'b0;
    end

    // remembers a missed refresh so a later enable resets at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wdg_expired <= 1'b0;
        else if (wdg_end && !watchdog_delay_bit)
            wdg_expired <= 1'b1;
        else if (delay_write)
            wdg_expired <= 1'b0;
    end

    // survives ordinary resets; only the low-voltage reset or a status read clears it
    always_ff @(posedge clk_i)
    begin
        if (lvd_reset_i)
            watchdog_reset_flag <= 1'b0;
        else if (rst_i)
            watchdog_reset_flag <= watchdog_reset_flag;
        else if (wdg_fire || (csr_write && dat_i[`LT_CSR_WDG_RF]))
            watchdog_reset_flag <= 1'b1;
        else if (csr_read)
            watchdog_reset_flag <= 1'b0;
    end

    // reset request holds until the system reset arrives
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            watchdog_reset_o <= 1'b0;
        else if (wdg_fire)
            watchdog_reset_o <= 1'b1;
    end

    // ============================================================
    // Input capture
    // ============================================================
    logic [2:0] pin_sync;
    logic pin_level;
    logic cap_edge;
    logic capture_flag;
    logic [7:0] capture_register;

    // three flops; a change counts once the last two agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_sync <= 3'b000;
        else
            pin_sync <= {pin_sync[1:0], capture_input_pin_i};
    end

    // Accepted pin level; either direction of change is an edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_level <= 1'b0;
        else if (pin_sync[1] == pin_sync[2])
            pin_level <= pin_sync[2];
    end

    assign cap_edge = run && (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_level);

    // latch upper count bits only while the flag is clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            capture_register <= `LT_CAP_RESET;
        else if (cap_edge && !capture_flag)
            capture_register <= count[12:5];
    end

    // flag set by capture, cleared by register read; set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            capture_flag <= 1'b0;
        else if (cap_edge && !capture_flag)
            capture_flag <= 1'b1;
        else if (cap_read)
            capture_flag <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            capture_irq_o <= 1'b0;
        else
            capture_irq_o <= capture_flag && capture_irq_enable;
    end

    // ============================================================
    // Wishbone answer
    // ============================================================
    logic [7:0] csr_value;

    assign csr_value = {capture_irq_enable, capture_flag, period_double_select, period_irq_enable,
                        period_event_flag, watchdog_reset_flag, watchdog_enable_bit, watchdog_delay_bit};

    // One-cycle ack; unmapped addresses answer with zero data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= take;
            if (take && !we_i)
            begin
                if (csr_hit)
                    dat_o <= {24'h00_0000, csr_value};
                else if (cap_hit)
                    dat_o <= {24'h00_0000, capture_register};
                else
                    dat_o <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    logic prev_ovf_event;

    // Remembers whether the last overflow gave a doubled-mode event; two in a row halve the period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev_ovf_event <= 1'b0;
        else if (overflow)
            prev_ovf_event <= tb_event && period_double_select;
    end

    a_count_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        overflow |=> (count == 13'h0000))
        else $error("count did not wrap to zero after terminal value");

    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && !overflow) |=> (count == $past(count) + 13'h0001))
        else $error("count did not step by one");

    a_count_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run) |=> $stable(count))
        else $error("count moved while halted");

    a_tb_double: assert property (@(posedge clk_i) disable iff (rst_i)
        (overflow && period_double_select && prev_ovf_event) |-> !tb_event)
        else $error("doubled timebase gave events on two overflows in a row");

    a_tb_flag_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (tb_event && period_irq_enable && !csr_write) |=> period_event_flag ##1 period_irq_o)
        else $error("timebase event did not reach the interrupt");

    a_csr_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (csr_read && !tb_event) |=> !period_event_flag)
        else $error("status read did not clear the period flag");

    a_wdg_fire: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && wdg_active && wdg_expired) |=> watchdog_reset_o && watchdog_reset_flag)
        else $error("expired watchdog did not reset");

    a_delay_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wdg_end && !delay_write) |=> !watchdog_delay_bit)
        else $error("delay bit survived the period end");

    a_halt_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (osc_state == OSC_HALTED && !watchdog_reset_o) |=> !watchdog_reset_o)
        else $error("watchdog reset raised while halted");

    a_wake_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        (osc_state == OSC_WAKING && $past(osc_state) == OSC_HALTED) |-> (osc_state == OSC_WAKING)[*4])
        else $error("counter resumed too soon after wake");

    a_cap_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_edge && !capture_flag) |=> capture_flag && (capture_register == $past(count[12:5])))
        else $error("capture did not latch the upper count bits");

    a_cap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        capture_flag |=> $stable(capture_register))
        else $error("capture register changed while flag set");

    a_cap_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_read && !cap_edge) |=> !capture_flag)
        else $error("capture register read did not clear the flag");

endmodule : lite_timebase_watchdog_capture
`default_nettype wire

// ### testbench/capture_pin_model.sv
// Behavioural source that drives the external capture pin
`timescale 1ns/1ns
`default_nettype none

module capture_pin_model
(
    // Clock and toggle request
    input wire logic clk_i,
    input wire logic flip_i,
    // Pin level
    output logic pin_o
);
    logic level = 1'b0;

    // Pin only changes on request, so a capture is never made by accident
    always @(posedge clk_i)
    begin
        if (flip_i)
        begin
            level <= !level;
        end
    end

    assign pin_o = level;
endmodule : capture_pin_model

`default_nettype wire

// ### testbench/lite_timebase_watchdog_capture_bench.sv
// Self-checking bench for the timebase, watchdog and capture block
`timescale 1ns/1ns
`default_nettype none

module lite_timebase_watchdog_capture_bench;
    typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic lvd_i = 1'b1;
    logic cyc_i = 1'b0;
    logic we_i = 1'b0;
    logic hw_i = 1'b0;
    logic hro_i = 1'b0;
    logic halt_i = 1'b0;
    logic wdl_i = 1'b0;
    logic flip = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o, pin, pirq, cirq, wrst;
    logic [2:0] outs;
    logic [12:0] cnt = 13'h0000;
    logic [7:0] e1, e2;
    int wake = 0;
    int cycles = 0;
    int t0, hit;
    int num_errors = 0;
    int total_checks = 0;
    // Plain register accesses: write, then read back
    row_t rows [5] = '{'{8'h2c, 8'h90, 8'h90}, '{8'h2c, 8'h21, 8'h21}, '{8'h2c, 8'h00, 8'h01},
                       '{8'h30, 8'hff, 8'h00}, '{8'h40, 8'hff, 8'h00}};

    // =========================================================
    // Clock, instances and reference counter
    always #2 clk_i = ~clk_i;
    assign outs = {wrst, cirq, pirq};

    lite_timebase_watchdog_capture #(.WAKE_SHORT(4), .WAKE_LONG(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .lvd_reset_i(lvd_i), .cyc_i(cyc_i), .stb_i(cyc_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .hw_watchdog_option_i(hw_i), .halt_reset_option_i(hro_i), .wake_delay_long_i(wdl_i),
        .halt_i(halt_i), .capture_input_pin_i(pin), .period_irq_o(pirq),
        .capture_irq_o(cirq), .watchdog_reset_o(wrst));

    capture_pin_model i_pin (.clk_i(clk_i), .flip_i(flip), .pin_o(pin));

    // Expected count; frozen in halt and during the wake delay; a reset drops a pending wake
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (rst_i)
        begin
            cnt <= 13'h0000;
            wake <= 0;
        end
        else if (halt_i)
            wake <= wdl_i ? 8 : 4;
        else if (wake != 0)
            wake <= wake - 1;
        else
            cnt <= (cnt == 13'h1f39) ? 13'h0000 : cnt + 13'h0001;
    end

    // =========================================================
    // Tasks
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        if (n >= 20)
        begin
            check("ack_o", 1, 0);
            end_sim;
        end
    endtask : wb

    task automatic wait_for(input int which, input int lim, output int got);
        got = 0;
        for (int i = 0; i < lim && got == 0; i++)
        begin
            @(posedge clk_i);
            got = int'(outs[which] === 1'b1);
        end
    endtask : wait_for

    // An expected event that never comes ends the run
    task automatic need(input int which, input int lim);
        int got;
        wait_for(which, lim, got);
        if (got == 0)
        begin
            check("event", 1, 0);
            end_sim;
        end
    endtask : need

    // Toggle mid-way through a 32-count step, so sync lag stays in the same byte
    task automatic capture(output logic [7:0] e);
        int n = 0;
        while (cnt[4:0] != 5'h10 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        e = cnt[12:5];
        flip <= 1'b1;
        @(posedge clk_i);
        flip <= 1'b0;
    endtask : capture

    task automatic do_reset(input logic lvd);
        rst_i <= 1'b1;
        lvd_i <= lvd;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        lvd_i <= 1'b0;
    endtask : do_reset

    // =========================================================
    // Main sequence
    initial
    begin
        do_reset(1'b1);
        @(posedge clk_i);
        check("period_irq_o", 0, pirq);
        check("watchdog_reset_o", 0, wrst);
        wb(0, 8'h30, 8'h00, rd);
        check("capture_register", 0, rd);
        for (int i = 0; i < 5; i++)
        begin
            wb(1, rows[i].adr, rows[i].wd, rd);
            wb(0, rows[i].adr, 8'h00, rd);
            check("register", {24'h0, rows[i].exp}, rd);
        end
        // Second edge while the flag is set must be ignored
        wb(1, 8'h2c, 8'h80, rd);
        capture(e1);
        need(1, 12);
        repeat (40) @(posedge clk_i);
        capture(e2);
        repeat (12) @(posedge clk_i);
        wb(0, 8'h30, 8'h00, rd);
        check("capture_register", {24'h0, e1}, rd);
        wb(0, 8'h2c, 8'h00, rd);
        check("capture_flag", 0, rd[6]);
        // Halt with the short, then the long wake delay
        for (int k = 0; k < 2; k++)
        begin
            wdl_i <= k[0];
            halt_i <= 1'b1;
            repeat (300) @(posedge clk_i);
            halt_i <= 1'b0;
            repeat (12) @(posedge clk_i);
            capture(e1);
            need(1, 40);
            wb(0, 8'h30, 8'h00, rd);
            check("capture_after_halt", {24'h0, e1}, rd);
        end
        // Timebase spacing, single and doubled
        wb(1, 8'h2c, 8'h10, rd);
        need(0, 8100);
        t0 = cycles;
        wb(0, 8'h2c, 8'h00, rd);
        check("period_event_flag", 1, rd[3]);
        need(0, 8100);
        check("single_period", 7994, cycles - t0);
        wb(0, 8'h2c, 8'h00, rd);
        wb(1, 8'h2c, 8'h30, rd);
        need(0, 16100);
        t0 = cycles;
        wb(0, 8'h2c, 8'h00, rd);
        need(0, 16100);
        check("double_period", 15988, cycles - t0);
        // Enabling long after an unrefreshed period resets at once
        wb(1, 8'h2c, 8'h02, rd);
        need(2, 4);
        do_reset(1'b0);
        wb(0, 8'h2c, 8'h00, rd);
        check("reset_flag_kept", 32'h04, rd);
        wb(0, 8'h2c, 8'h00, rd);
        check("reset_flag_read", 32'h00, rd);
        // Forced reset, then a stale flag resets on enable
        wb(1, 8'h2c, 8'h02, rd);
        wait_for(2, 20, hit);
        check("early_enable", 0, hit);
        wb(1, 8'h2c, 8'h06, rd);
        need(2, 4);
        do_reset(1'b0);
        wb(1, 8'h2c, 8'h02, rd);
        need(2, 4);
        do_reset(1'b0);
        wb(0, 8'h2c, 8'h00, rd);
        // Refresh more often than the period keeps the device alive
        wb(1, 8'h2c, 8'h01, rd);
        wb(1, 8'h2c, 8'h03, rd);
        for (int i = 0; i < 3; i++)
        begin
            wait_for(2, 6000, hit);
            check("refreshed", 0, hit);
            wb(1, 8'h2c, 8'h03, rd);
        end
        // Halt with the reset-on-halt option
        do_reset(1'b0);
        hro_i <= 1'b1;
        wb(1, 8'h2c, 8'h03, rd);
        halt_i <= 1'b1;
        need(2, 6);
        halt_i <= 1'b0;
        hro_i <= 1'b0;
        do_reset(1'b1);
        wb(0, 8'h2c, 8'h00, rd);
        check("lvd_clears_flag", 32'h00, rd);
        // Hardware option ignores the enable bit
        hw_i <= 1'b1;
        wb(1, 8'h2c, 8'h04, rd);
        need(2, 4);
        end_sim;
    end
endmodule : lite_timebase_watchdog_capture_bench

`default_nettype wire
